//--- src/key_builder_pkg.sv
// package: key bit positions, field widths, frame classes and register map
// assumes: one switch core clock; parser and lookup share it
package key_builder_pkg;

   // key span covered by this block
   localparam int KEY_LSB = 65;
   localparam int KEY_MSB = 268;

   // seven-tuple key field positions and widths
   localparam int DMAC_POS = 65;
   localparam int SMAC_POS = 113;
   localparam int MAC_W = 48;
   localparam int TYPE_FLAG_POS = 161;
   localparam int TYPE_FIELD_POS = 162;
   localparam int TYPE_W = 16;
   localparam int IP_OR_SNAP_FLAG_POS = 178;
   localparam int IPV4_POS = 179;
   localparam int FRAG_POS = 180;
   localparam int NONFIRST_POS = 181;
   localparam int OPTIONS_POS = 182;
   localparam int DSCP_POS = 183;
   localparam int DSCP_W = 6;
   localparam int DIP_MSB_POS = 189;
   localparam int DIP_MSB_W = 16;
   localparam int DIP_LOW_POS = 205;
   localparam int DIP_LOW_W = 64;

   // ipv6 normal key payload field
   localparam int V6_PAYLOAD_POS = 265;
   localparam int V6_PAYLOAD_W = 112;

   // frame facts
   localparam logic [15:0] TYPE_ENCODED_MIN = 16'h0600;
   localparam logic [15:0] OAM_OVERLOADED_TYPE_FIELD = 16'h8902;
   localparam logic [7:0] OAM_TYPE_HI = 8'h89;
   localparam logic [3:0] IHL_MIN = 4'h5;
   localparam int PAYLOAD_W = 128;
   localparam int SNAP_PID_W = 40;
   localparam int MEL_W = 7;

   // register map (byte addresses)
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] COUNT_ADDR = 8'h08;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_CLR_BIT = 1;
   localparam logic CTRL_EN_RESET = 1'h1;
   localparam int STAT_CLASS_POS = 0;
   localparam int STAT_FLAGS_POS = 4;
   localparam int STAT_EN_POS = 12;

   typedef enum logic [2:0] {
      CLASS_LLC = 3'h0,
      CLASS_SNAP = 3'h1,
      CLASS_IPV4 = 3'h2,
      CLASS_IPV6 = 3'h3,
      CLASS_ARP = 3'h4,
      CLASS_OVERLOADED_TYPE_FIELD = 3'h5,
      CLASS_OAM = 3'h6
   } frame_class_t;

endpackage : key_builder_pkg

//--- src/type_field_select.sv
// overloaded type field and low destination field selection per frame class
// assumes: purely combinational; the caller registers the results
module type_field_select (
   input wire key_builder_pkg::frame_class_t class_i,
   input wire logic [15:0] overloaded_type_field_i,
   input wire logic [7:0] dsap_i,
   input wire logic [7:0] ssap_i,
   input wire logic [key_builder_pkg::SNAP_PID_W-1:0] snap_pid_i,
   input wire logic l4_tcp_udp_i,
   input wire logic [15:0] l4_dport_i,
   input wire logic [7:0] ip_proto_i,
   input wire logic oam_masq_i,
   input wire logic [key_builder_pkg::MEL_W-1:0] oam_mel_i,
   input wire logic [31:0] ipv4_dip_i,
   input wire logic [127:0] ipv6_dip_i,
   input wire logic [key_builder_pkg::PAYLOAD_W-1:0] payload_i,
   output logic [key_builder_pkg::TYPE_W-1:0] type_field_o,
   output logic oam_ind_o,
   output logic [key_builder_pkg::DIP_LOW_W-1:0] dip_low_o
);
   // -------------------------------------------------------------
   // class decode
   // -------------------------------------------------------------
   wire is_llc = (class_i == key_builder_pkg::CLASS_LLC);
   wire is_snap = (class_i == key_builder_pkg::CLASS_SNAP);
   wire is_ip4 = (class_i == key_builder_pkg::CLASS_IPV4);
   wire is_ip6 = (class_i == key_builder_pkg::CLASS_IPV6);
   wire is_ip = is_ip4 | is_ip6;
   wire is_oam = (class_i == key_builder_pkg::CLASS_OAM) && (overloaded_type_field_i == key_builder_pkg::OAM_OVERLOADED_TYPE_FIELD);
   wire is_plain = (class_i == key_builder_pkg::CLASS_ARP) || (class_i == key_builder_pkg::CLASS_OVERLOADED_TYPE_FIELD)
      || (class_i == key_builder_pkg::CLASS_OAM);

   // -------------------------------------------------------------
   // overloaded type field
   // -------------------------------------------------------------
   wire [15:0] ip_sel = l4_tcp_udp_i ? l4_dport_i : {8'h00, ip_proto_i};
   wire [15:0] oam_sel = {key_builder_pkg::OAM_TYPE_HI, oam_masq_i, oam_mel_i};

   assign type_field_o = is_oam ? oam_sel :
      is_llc ? {dsap_i, ssap_i} :
      is_snap ? snap_pid_i[39:24] :
      is_ip ? ip_sel :
      is_plain ? overloaded_type_field_i : 16'h0000;
   assign oam_ind_o = is_oam;

   // -------------------------------------------------------------
   // low destination field; payload byte 0 sits in the low bits
   // -------------------------------------------------------------
   assign dip_low_o = is_ip6 ? ipv6_dip_i[63:0] :
      is_ip4 ? {32'h0000_0000, ipv4_dip_i} :
      is_llc ? payload_i[71:8] :
      is_snap ? payload_i[87:24] :
      (is_plain | is_oam) ? payload_i[63:0] : 64'h0;

endmodule : type_field_select

//--- src/seven_tuple_key_builder.sv
// seven-tuple key builder: bits 65 to 268 plus the ipv6 normal payload field
// assumes: parser on mclk_i presents one frame per frame_valid_i pulse;
// the lookup reads the registered key while key_valid_o is high
//
// Contract
// - ipv6 normal key carries 112 payload bits after the header from bit 265
// - destination mac address occupies 48 bits from key bit 65
// - source mac address occupies 48 bits from key bit 113
// - bit 161 set when type/length is at least 0x600, else cleared
// - 16-bit field at 162 selected by frame class as listed
// - oam frames put 0x89, masquerade bit and meg level in that field when the type field is 0x8902
// - oam overload indicator set whenever the field carries oam encoding
// - bit 178 set for ipv4, ipv6 or snap frames only
// - bit 179 set only for ipv4 frames
// - bit 180 set when ipv4 more-fragments is one or offset nonzero
// - bit 181 set when ipv4 fragment offset is above zero
// - translated six-bit dscp placed from key bit 183
// - ipv6 destination address bits 127:112 placed from key bit 189
// - 64-bit field at 205 carries low dip or payload bytes
module seven_tuple_key_builder #(
   parameter int ADDR_W = 8,
   parameter int COUNT_W = 32
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // parser side
   input wire logic frame_valid_i,
   input wire key_builder_pkg::frame_class_t frame_class_i,
   input wire logic [47:0] dmac_i,
   input wire logic [47:0] smac_i,
   input wire logic [15:0] type_encoded_flag_i,
   input wire logic [7:0] dsap_i,
   input wire logic [7:0] ssap_i,
   input wire logic [key_builder_pkg::SNAP_PID_W-1:0] snap_pid_i,
   input wire logic l4_tcp_udp_i,
   input wire logic [15:0] l4_dport_i,
   input wire logic [7:0] ip_proto_i,
   input wire logic ipv4_more_frag_i,
   input wire logic [12:0] ipv4_frag_ofs_i,
   input wire logic [3:0] ipv4_ihl_i,
   input wire logic [5:0] dscp_xlated_i,
   input wire logic [31:0] ipv4_dip_i,
   input wire logic [127:0] ipv6_dip_i,
   input wire logic oam_masq_i,
   input wire logic [key_builder_pkg::MEL_W-1:0] oam_mel_i,
   input wire logic [key_builder_pkg::PAYLOAD_W-1:0] payload_i,
   input wire logic [key_builder_pkg::V6_PAYLOAD_W-1:0] ipv6_payload_i,
   // lookup side
   output logic key_valid_o,
   output logic [key_builder_pkg::KEY_MSB:key_builder_pkg::KEY_LSB] seven_tuple_key_o,
   output logic oam_overload_indicator_o,
   output logic [key_builder_pkg::V6_PAYLOAD_W-1:0] ipv6_payload_bytes_o
);

   // ------------------------------------------------------------------
   // register state
   // ------------------------------------------------------------------
   logic enable;
   logic [COUNT_W-1:0] frame_count;
   key_builder_pkg::frame_class_t last_class;
   logic [7:0] last_flags;

   // ------------------------------------------------------------------
   // frame class decode
   // ------------------------------------------------------------------
   wire is_snap = (frame_class_i == key_builder_pkg::CLASS_SNAP);
   wire is_ipv4 = (frame_class_i == key_builder_pkg::CLASS_IPV4);
   wire is_ipv6 = (frame_class_i == key_builder_pkg::CLASS_IPV6);
   wire is_ip = is_ipv4 | is_ipv6;
   wire take_frame = frame_valid_i & enable;

   // ------------------------------------------------------------------
   // flag terms
   // ------------------------------------------------------------------
   wire type_encoded_flag = (type_encoded_flag_i >= key_builder_pkg::TYPE_ENCODED_MIN);
   wire ip_or_snap_flag = is_ip | is_snap;
   wire ipv4_flag = is_ipv4;
   wire frag_ofs_nonzero = (ipv4_frag_ofs_i != 13'h0000);
   wire fragmented_flag = is_ipv4 & (ipv4_more_frag_i | frag_ofs_nonzero);
   wire non_first_fragment_flag = is_ipv4 & frag_ofs_nonzero;
   wire ip_options_flag = is_ipv4 & (ipv4_ihl_i > key_builder_pkg::IHL_MIN);

   // ------------------------------------------------------------------
   // field terms
   // ------------------------------------------------------------------
   wire [5:0] dscp_field = is_ip ? dscp_xlated_i : 6'h00;
   wire [15:0] dest_ipv6_top_bits = is_ipv6 ? ipv6_dip_i[127:112] : 16'h0000;
   wire [key_builder_pkg::V6_PAYLOAD_W-1:0] next_v6_payload;
   assign next_v6_payload = is_ipv6 ? ipv6_payload_i : '0;

   logic [15:0] overloaded_type_field;
   logic oam_overload_indicator;
   logic [63:0] dest_ip_low_field;

   type_field_select u_type_field_select (
      .class_i(frame_class_i),
      .overloaded_type_field_i(type_encoded_flag_i),
      .dsap_i(dsap_i),
      .ssap_i(ssap_i),
      .snap_pid_i(snap_pid_i),
      .l4_tcp_udp_i(l4_tcp_udp_i),
      .l4_dport_i(l4_dport_i),
      .ip_proto_i(ip_proto_i),
      .oam_masq_i(oam_masq_i),
      .oam_mel_i(oam_mel_i),
      .ipv4_dip_i(ipv4_dip_i),
      .ipv6_dip_i(ipv6_dip_i),
      .payload_i(payload_i),
      .type_field_o(overloaded_type_field),
      .oam_ind_o(oam_overload_indicator),
      .dip_low_o(dest_ip_low_field)
   );

   // ------------------------------------------------------------------
   // key assembly
   // ------------------------------------------------------------------
   wire [key_builder_pkg::KEY_MSB:key_builder_pkg::KEY_LSB] next_key;

   assign next_key[key_builder_pkg::DMAC_POS +: key_builder_pkg::MAC_W] = dmac_i;
   assign next_key[key_builder_pkg::SMAC_POS +: key_builder_pkg::MAC_W] = smac_i;
   assign next_key[key_builder_pkg::TYPE_FLAG_POS] = type_encoded_flag;
   assign next_key[key_builder_pkg::TYPE_FIELD_POS +: key_builder_pkg::TYPE_W] = overloaded_type_field;
   assign next_key[key_builder_pkg::IP_OR_SNAP_FLAG_POS] = ip_or_snap_flag;
   assign next_key[key_builder_pkg::IPV4_POS] = ipv4_flag;
   assign next_key[key_builder_pkg::FRAG_POS] = fragmented_flag;
   assign next_key[key_builder_pkg::NONFIRST_POS] = non_first_fragment_flag;
   assign next_key[key_builder_pkg::OPTIONS_POS] = ip_options_flag;
   assign next_key[key_builder_pkg::DSCP_POS +: key_builder_pkg::DSCP_W] = dscp_field;
   assign next_key[key_builder_pkg::DIP_MSB_POS +: key_builder_pkg::DIP_MSB_W] = dest_ipv6_top_bits;
   assign next_key[key_builder_pkg::DIP_LOW_POS +: key_builder_pkg::DIP_LOW_W] = dest_ip_low_field;

   // ------------------------------------------------------------------
   // key output registers; key holds until the next accepted frame
   // ------------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         key_valid_o <= 1'b0;
         seven_tuple_key_o <= '0;
         oam_overload_indicator_o <= 1'b0;
         ipv6_payload_bytes_o <= '0;
      end else begin
         key_valid_o <= take_frame;
         if (take_frame) begin
            seven_tuple_key_o <= next_key;
            oam_overload_indicator_o <= oam_overload_indicator;
            ipv6_payload_bytes_o <= next_v6_payload;
         end
      end
   end

   // ------------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------------
   wire setup_phase = psel_i & ~penable_i;
   wire access_done = psel_i & penable_i & pready_o;
   wire hit_ctrl = (paddr_i == key_builder_pkg::CTRL_ADDR);
   wire hit_status = (paddr_i == key_builder_pkg::STATUS_ADDR);
   wire hit_count = (paddr_i == key_builder_pkg::COUNT_ADDR);
   wire hit_any = hit_ctrl | hit_status | hit_count;
   wire ctrl_write = access_done & pwrite_i & hit_ctrl & pstrb_i[0];
   wire clear_count = ctrl_write & pwdata_i[key_builder_pkg::CTRL_CLR_BIT];

   wire [7:0] next_flags = {
      1'b0,
      oam_overload_indicator,
      ip_options_flag,
      non_first_fragment_flag,
      fragmented_flag,
      ipv4_flag,
      ip_or_snap_flag,
      type_encoded_flag
   };

   wire [31:0] ctrl_word = {31'h0000_0000, enable};
   wire [31:0] status_word = (32'({3'h0, enable}) << key_builder_pkg::STAT_EN_POS)
      | (32'(last_flags) << key_builder_pkg::STAT_FLAGS_POS)
      | (32'(last_class) << key_builder_pkg::STAT_CLASS_POS);
   wire [31:0] count_word = 32'(frame_count);

   wire [31:0] next_rdata = hit_ctrl ? ctrl_word :
      hit_status ? status_word :
      hit_count ? count_word : 32'h0000_0000;

   // ------------------------------------------------------------------
   // apb response: ready one cycle after setup, no wait states
   // ------------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pready_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= setup_phase;
         prdata_o <= (setup_phase & ~pwrite_i) ? next_rdata : 32'h0000_0000;
         pslverr_o <= setup_phase & ~hit_any;
      end
   end

   // ------------------------------------------------------------------
   // control register
   // ------------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         enable <= key_builder_pkg::CTRL_EN_RESET;
      end else if (ctrl_write) begin
         enable <= pwdata_i[key_builder_pkg::CTRL_EN_BIT];
      end
   end

   // ------------------------------------------------------------------
   // status capture and frame counter; a frame in the clear cycle counts
   // ------------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         frame_count <= '0;
      end else if (clear_count) begin
         frame_count <= take_frame ? COUNT_W'(1) : '0;
      end else if (take_frame) begin
         frame_count <= frame_count + COUNT_W'(1);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         last_class <= key_builder_pkg::CLASS_LLC;
         last_flags <= 8'h00;
      end else if (take_frame) begin
         last_class <= frame_class_i;
         last_flags <= next_flags;
      end
   end

endmodule : seven_tuple_key_builder

//--- testbench/key_builder_asserts.sv
// checker: port-level assertions on the key builder, bound to its top module
// assumes: key fields are registered one cycle after an accepted frame
module key_builder_asserts (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pready_o,
   input wire logic frame_valid_i,
   input wire key_builder_pkg::frame_class_t frame_class_i,
   input wire logic [47:0] dmac_i,
   input wire logic [47:0] smac_i,
   input wire logic [15:0] type_encoded_flag_i,
   input wire logic ipv4_more_frag_i,
   input wire logic [12:0] ipv4_frag_ofs_i,
   input wire logic [3:0] ipv4_ihl_i,
   input wire logic key_valid_o,
   input wire logic [key_builder_pkg::KEY_MSB:key_builder_pkg::KEY_LSB] seven_tuple_key_o,
   input wire logic oam_overload_indicator_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // frame class of the previous cycle
   // ----------------------------------------
   logic was_v4;
   logic was_ip_or_snap_flag;
   logic was_oam;
   always_ff @(posedge mclk_i) begin
      was_v4 <= frame_class_i == key_builder_pkg::CLASS_IPV4;
      was_ip_or_snap_flag <= frame_class_i inside {key_builder_pkg::CLASS_IPV4, key_builder_pkg::CLASS_IPV6,
         key_builder_pkg::CLASS_SNAP};
      was_oam <= frame_class_i == key_builder_pkg::CLASS_OAM && type_encoded_flag_i == key_builder_pkg::OAM_OVERLOADED_TYPE_FIELD;
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   sequence apb_setup;
      psel_i && !penable_i;
   endsequence
   sequence apb_answer;
      psel_i && penable_i && pready_o;
   endsequence
   apb_ready_a: assert property (apb_setup |=> apb_answer)
      else $error("no ready in the access cycle");
   key_cause_a: assert property (key_valid_o |-> $past(frame_valid_i))
      else $error("key presented without a frame");
   dmac_place_a: assert property (key_valid_o |-> seven_tuple_key_o[112:65] == $past(dmac_i))
      else $error("destination mac misplaced");
   smac_place_a: assert property (key_valid_o |-> seven_tuple_key_o[160:113] == $past(smac_i))
      else $error("source mac misplaced");
   type_flag_a: assert property (key_valid_o |-> seven_tuple_key_o[161] == ($past(type_encoded_flag_i) >= 16'h0600))
      else $error("type encoded flag wrong");
   oam_flag_a: assert property (key_valid_o |-> oam_overload_indicator_o == was_oam)
      else $error("oam indicator wrong");
   ip_or_snap_flag_a: assert property (key_valid_o |-> seven_tuple_key_o[178] == was_ip_or_snap_flag)
      else $error("ip or snap flag wrong");
   v4_flag_a: assert property (key_valid_o |-> seven_tuple_key_o[179] == was_v4)
      else $error("ipv4 flag wrong");
   frag_flag_a: assert property (key_valid_o |-> seven_tuple_key_o[180] ==
      (was_v4 && ($past(ipv4_more_frag_i) || $past(ipv4_frag_ofs_i) != 13'h0))) else $error("fragment flag wrong");
   non_first_a: assert property (key_valid_o |-> seven_tuple_key_o[181] ==
      (was_v4 && $past(ipv4_frag_ofs_i) != 13'h0)) else $error("non-first fragment flag wrong");
   options_flag_a: assert property (key_valid_o |-> seven_tuple_key_o[182] ==
      (was_v4 && $past(ipv4_ihl_i) > 4'h5)) else $error("options flag wrong");
endmodule : key_builder_asserts

bind seven_tuple_key_builder key_builder_asserts chk (.mclk_i, .rst_i, .psel_i, .penable_i, .pready_o,
   .frame_valid_i, .frame_class_i, .dmac_i, .smac_i, .type_encoded_flag_i, .ipv4_more_frag_i, .ipv4_frag_ofs_i,
   .ipv4_ihl_i, .key_valid_o, .seven_tuple_key_o, .oam_overload_indicator_o);

//--- testbench/key_lookup_model.sv
// lookup model: counts presented keys and judges layer 4 trust
// assumes: key and flags hold between key_valid pulses
module key_lookup_model (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic key_valid_i,
   input wire logic [268:65] key_i,
   output logic [15:0] seen_o,
   output logic l4_trust_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // matching side
   // ----------------------------------------
   assign l4_trust_o = ~|key_i[182:180];
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         seen_o <= 16'h0;
      end else if (key_valid_i) begin
         seen_o <= seen_o + 16'h1;
      end
   end
endmodule : key_lookup_model

//--- testbench/seven_tuple_key_builder_tb.sv
// testbench: frame class table, then register, enable and reset cases
// assumes: package, design, checker and lookup model compiled first
module seven_tuple_key_builder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [2:0] cls;
      logic [15:0] et;
      logic [3:0] tcp_masq_mf;
      logic [12:0] ofs;
      logic [3:0] ihl;
      logic [4:0] flg;
      logic ind;
   } row_t;
   row_t rows [11] = '{'{3'h0, 16'h05ff, 4'h0, 13'h0, 4'h5, 5'h00, 1'h0},
      '{3'h1, 16'h0028, 4'h0, 13'h0, 4'h5, 5'h01, 1'h0}, '{3'h2, 16'h0800, 4'h4, 13'h0, 4'h5, 5'h03, 1'h0},
      '{3'h2, 16'h0800, 4'h1, 13'h0, 4'h6, 5'h17, 1'h0}, '{3'h2, 16'h0800, 4'h4, 13'h1, 4'h5, 5'h0f, 1'h0},
      '{3'h3, 16'h86dd, 4'h5, 13'h1, 4'h6, 5'h01, 1'h0}, '{3'h4, 16'h0806, 4'h0, 13'h0, 4'h5, 5'h00, 1'h0},
      '{3'h5, 16'h0600, 4'h0, 13'h0, 4'h5, 5'h00, 1'h0}, '{3'h6, 16'h8902, 4'h2, 13'h0, 4'h5, 5'h00, 1'h1},
      '{3'h6, 16'h8902, 4'h0, 13'h0, 4'h5, 5'h00, 1'h1}, '{3'h6, 16'h88b6, 4'h2, 13'h0, 4'h5, 5'h00, 1'h0}};
   logic mclk_i = 1'h0, rst_i = 1'h1, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0, frame_valid_i = 1'h0;
   logic l4_tcp_udp_i = 1'h0, ipv4_more_frag_i = 1'h0, oam_masq_i = 1'h0, pready_o, pslverr_o, key_valid_o, e;
   logic [7:0] paddr_i = 8'h0, dsap_i = 8'h0, ssap_i = 8'h0, ip_proto_i = 8'h0;
   logic [31:0] pwdata_i = 32'h0, ipv4_dip_i = 32'h0, prdata_o, q;
   logic [3:0] pstrb_i = 4'hf, ipv4_ihl_i = 4'h5;
   logic [47:0] dmac_i = 48'h0, smac_i = 48'h0;
   logic [15:0] type_encoded_flag_i = 16'h0, l4_dport_i = 16'h0, seen;
   logic [12:0] ipv4_frag_ofs_i = 13'h0;
   logic [127:0] ipv6_dip_i = 128'h0, payload_i = 128'h0;
   logic [111:0] ipv6_payload_i = 112'h0, ipv6_payload_bytes_o;
   logic [39:0] snap_pid_i = 40'h0;
   logic [6:0] oam_mel_i = 7'h0;
   logic [5:0] dscp_xlated_i = 6'h0;
   logic [268:65] seven_tuple_key_o;
   logic oam_overload_indicator_o, l4_trust;
   key_builder_pkg::frame_class_t frame_class_i = key_builder_pkg::CLASS_LLC;
   int fail_count = 0;
   int tests_run = 0;
   seven_tuple_key_builder dut (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
      .prdata_o, .pready_o, .pslverr_o, .frame_valid_i, .frame_class_i, .dmac_i, .smac_i, .type_encoded_flag_i, .dsap_i,
      .ssap_i, .snap_pid_i, .l4_tcp_udp_i, .l4_dport_i, .ip_proto_i, .ipv4_more_frag_i, .ipv4_frag_ofs_i,
      .ipv4_ihl_i, .dscp_xlated_i, .ipv4_dip_i, .ipv6_dip_i, .oam_masq_i, .oam_mel_i, .payload_i, .ipv6_payload_i,
      .key_valid_o, .seven_tuple_key_o, .oam_overload_indicator_o, .ipv6_payload_bytes_o);
   key_lookup_model lookup (.mclk_i, .rst_i, .key_valid_i(key_valid_o), .key_i(seven_tuple_key_o),
      .seen_o(seen), .l4_trust_o(l4_trust));
   always #2 mclk_i = ~mclk_i;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [127:0] s, input logic [127:0] x);
      tests_run++;
      if (s !== x) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, x);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk_i);
      {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'h1, wr, a, d};
      @(posedge mclk_i);
      penable_i <= 1'h1;
      do begin
         @(posedge mclk_i);
         n++;
      end while (pready_o !== 1'h1 && n < 16);
      {q, e} = {prdata_o, pslverr_o};
      {psel_i, penable_i} <= 2'h0;
      if (pready_o !== 1'h1) begin
         fail_count++;
         give_verdict();
      end
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'h0, a, 32'h0);
      chk({e, q}, {1'h0, x});
   endtask : rd
   task automatic send(input row_t r, input logic [7:0] s);
      @(posedge mclk_i);
      frame_valid_i <= 1'h1;
      frame_class_i <= key_builder_pkg::frame_class_t'(r.cls);
      {type_encoded_flag_i, l4_tcp_udp_i, oam_masq_i, ipv4_more_frag_i, ipv4_frag_ofs_i, ipv4_ihl_i} <=
         {r.et, r.tcp_masq_mf[2:0], r.ofs, r.ihl};
      {dmac_i, smac_i, dsap_i, ssap_i, l4_dport_i} <= {{6{s}} ^ 48'h0123456789ab, {6{~s}}, s, ~s, s, ~s};
      {snap_pid_i, ip_proto_i, dscp_xlated_i, ipv4_dip_i, oam_mel_i} <=
         {{5{s}} ^ 40'h0102030405, s ^ 8'h11, s[5:0], {4{~s}} ^ 32'hc0a80001, s[6:0]};
      {ipv6_dip_i, payload_i, ipv6_payload_i} <= {{16{s}} ^ 128'h2001, {16{~s}} ^ 128'h0123456789abcdef, {14{s}}};
      @(posedge mclk_i);
      frame_valid_i <= 1'h0;
      #1;
   endtask : send
   function automatic logic [15:0] exp_type(input row_t r);
      case (r.cls)
         3'h0: return {dsap_i, ssap_i};
         3'h1: return snap_pid_i[39:24];
         3'h2, 3'h3: return r.tcp_masq_mf[2] ? l4_dport_i : {8'h0, ip_proto_i};
         3'h6: return r.et == 16'h8902 ? {8'h89, r.tcp_masq_mf[1], oam_mel_i} : r.et;
         default: return r.et;
      endcase
   endfunction : exp_type
   function automatic logic [63:0] exp_low(input logic [2:0] c);
      case (c)
         3'h0: return payload_i[71:8];
         3'h1: return payload_i[87:24];
         3'h2: return {32'h0, ipv4_dip_i};
         3'h3: return ipv6_dip_i[63:0];
         default: return payload_i[63:0];
      endcase
   endfunction : exp_low
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      #100000;
      fail_count++;
      give_verdict();
   end
   initial begin
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'h0;
      rd(8'h00, 32'h1);
      rd(8'h04, 32'h1000);
      rd(8'h08, 32'h0);
      foreach (rows[i]) begin
         send(rows[i], 8'(i * 29 + 3));
         chk(key_valid_o, 1'h1);
         chk(seven_tuple_key_o[112:65], dmac_i);
         chk(seven_tuple_key_o[160:113], smac_i);
         chk(seven_tuple_key_o[161], rows[i].et >= 16'h0600);
         chk(seven_tuple_key_o[177:162], exp_type(rows[i]));
         chk(oam_overload_indicator_o, rows[i].ind);
         chk(seven_tuple_key_o[182:178], rows[i].flg);
         chk(seven_tuple_key_o[188:183], rows[i].cls inside {3'h2, 3'h3} ? dscp_xlated_i : 6'h0);
         chk(seven_tuple_key_o[204:189], rows[i].cls == 3'h3 ? ipv6_dip_i[127:112] : 16'h0);
         chk(seven_tuple_key_o[268:205], exp_low(rows[i].cls));
         chk(ipv6_payload_bytes_o, rows[i].cls == 3'h3 ? ipv6_payload_i : 112'h0);
         chk(l4_trust, rows[i].flg[4:2] == 3'h0);
      end
      // the model counts the last key at the edge after it is presented
      @(posedge mclk_i);
      #1;
      chk(seen, 16'h000b);
      rd(8'h08, 32'h0000000b);
      rd(8'h04, 32'h00001016);
      apb(1'h0, 8'h0c, 32'h0);
      chk({e, q}, 33'h100000000);
      apb(1'h1, 8'h08, 32'h5);
      rd(8'h08, 32'h0000000b);
      apb(1'h1, 8'h00, 32'h0);
      send(rows[2], 8'h77);
      chk(key_valid_o, 1'h0);
      rd(8'h08, 32'h0000000b);
      apb(1'h1, 8'h00, 32'h3);
      rd(8'h08, 32'h0);
      send(rows[5], 8'h12);
      chk(key_valid_o, 1'h1);
      // undefined class: every class-dependent field and flag stays zero
      send(row_t'{3'h7, 16'h0800, 4'h4, 13'h1, 4'h6, 5'h00, 1'h0}, 8'h5a);
      chk(seven_tuple_key_o[161], 1'h1);
      chk({|seven_tuple_key_o[268:162], |ipv6_payload_bytes_o, oam_overload_indicator_o}, 3'h0);
      // disable first so that reset has to bring the enable back
      apb(1'h1, 8'h00, 32'h0);
      @(posedge mclk_i);
      rst_i <= 1'h1;
      @(posedge mclk_i);
      rst_i <= 1'h0;
      #1;
      chk({|seven_tuple_key_o, key_valid_o, oam_overload_indicator_o, |ipv6_payload_bytes_o}, 4'h0);
      rd(8'h00, 32'h1);
      rd(8'h08, 32'h0);
      give_verdict();
   end
endmodule : seven_tuple_key_builder_tb
